// *** verilog/ramp_actual_state_regs.sv ***
// Motion-state registers of one axis behind an Avalon-MM slave
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ns
`default_nettype none
module ramp_actual_state_regs
  import ramp_regs_pkg::*;
#(
  parameter int VEL_W = VEL_W_DEF,
  parameter int ACC_W = ACC_W_DEF,
  parameter int VST_W = VST_W_DEF
)
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [BE_W-1:0] byteenable_i,
  input wire logic [DATA_W-1:0] writedata_i,
  output logic [DATA_W-1:0] readdata_o,
  output logic waitrequest_o,
  // Ramp generator side
  input wire motion_mode_t mode_i,
  input wire logic [POS_W-1:0] goal_position_i,
  input wire logic ramp_permit_i,
  input wire logic [VEL_W-1:0] ramp_velocity_i,
  input wire logic [ACC_W-1:0] ramp_accel_i,
  input wire logic step_i,
  output logic [POS_W-1:0] present_position_o,
  output logic [VST_W-1:0] launch_velocity_o,
  output logic move_start_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks: fields must leave room in one bus word
  if (VEL_W < 2 || VEL_W >= DATA_W)
  begin : g_bad_vel
    $error("VEL_W out of range");
  end
  if (ACC_W < 1 || ACC_W >= DATA_W)
  begin : g_bad_acc
    $error("ACC_W out of range");
  end
  if (VST_W < 1 || VST_W >= DATA_W)
  begin : g_bad_vst
    $error("VST_W out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [IDX_W-1:0] idx);
    reg_hit = (addr == {idx, 2'b00});
  endfunction

  logic [BE_W*LANE_W-1:0] be_mask;

  // Byte-enable mask, one lane per generate step
  for (genvar lane = 0; lane < BE_W; lane++)
  begin : g_lane
    assign be_mask[lane*LANE_W +: LANE_W] = {LANE_W{byteenable_i[lane]}};
  end

  function automatic logic [DATA_W-1:0] merge_lanes(input logic [DATA_W-1:0] old_val,
                                                    input logic [DATA_W-1:0] new_val,
                                                    input logic [DATA_W-1:0] mask);
    merge_lanes = (old_val & ~mask) | (new_val & mask);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle, then the request is taken
  // Fixed latency keeps the host side simple; every access costs two cycles
  logic wait_r;
  logic [DATA_W-1:0] readdata_r;
  logic req_seen;
  logic wr_take;
  logic rd_take;

  assign req_seen = (read_i || write_i) && wait_r;
  assign wr_take = write_i && !wait_r;
  assign rd_take = read_i && !wait_r;

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wait_r <= 1'b1;
    end
    else
    begin
      wait_r <= !req_seen;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Motion state storage
  logic [VEL_W-1:0] velocity_r;
  logic [ACC_W-1:0] accel_r;
  logic [VST_W-1:0] launch_r;
  logic [VST_W-1:0] launch_out_r;
  logic move_start_r;
  logic [POS_W-1:0] position;
  logic [POS_W-1:0] pos_wr_val;
  logic [DATA_W-1:0] launch_wr_val;
  logic pos_load;
  logic launch_load;

  assign pos_load = wr_take && reg_hit(address_i, IDX_POSITION);
  assign launch_load = wr_take && reg_hit(address_i, IDX_LAUNCH);
  assign pos_wr_val = merge_lanes(position, writedata_i, be_mask);
  assign launch_wr_val = merge_lanes({{(DATA_W-VST_W){1'b0}}, launch_r}, writedata_i, be_mask);

  // Direction of each step comes from the velocity sign the ramp reports
  axis_position_counter u_position
  (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .load_i(pos_load),
    .load_val_i(pos_wr_val),
    .step_i(step_i),
    .step_down_i(ramp_velocity_i[VEL_W-1]),
    .position_o(position)
  );

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      velocity_r <= '0;
    end
    else
    begin
      velocity_r <= ramp_velocity_i;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      accel_r <= '0;
    end
    else
    begin
      accel_r <= ramp_accel_i;
    end
  end

  // launch velocity store; upper bits dropped
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      launch_r <= '0;
    end
    else if (launch_load)
    begin
      launch_r <= launch_wr_val[VST_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      launch_out_r <= '0;
    end
    else
    begin
      launch_out_r <= (mode_i == MODE_POSITION) ? launch_r : '0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      move_start_r <= 1'b0;
    end
    else
    begin
      move_start_r <= pos_load && (mode_i == MODE_POSITION) &&
                      (pos_wr_val != goal_position_i) && ramp_permit_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; snapshot taken in the wait cycle so data is stable at the take
  logic [DATA_W-1:0] rd_mux;

  always_comb
  begin
    rd_mux = UNMAPPED_READ;
    if (reg_hit(address_i, IDX_POSITION))
    begin
      rd_mux = position;
    end
    else if (reg_hit(address_i, IDX_VELOCITY))
    begin
      rd_mux = {{(DATA_W-VEL_W){1'b0}}, velocity_r};
    end
    else if (reg_hit(address_i, IDX_ACCEL))
    begin
      rd_mux = {{(DATA_W-ACC_W){1'b0}}, accel_r};
    end
    else if (reg_hit(address_i, IDX_LAUNCH))
    begin
      rd_mux = {{(DATA_W-VST_W){1'b0}}, launch_r};
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      readdata_r <= READ_RST;
    end
    else if (read_i && wait_r)
    begin
      readdata_r <= rd_mux;
    end
  end

  assign readdata_o = readdata_r;
  assign waitrequest_o = wait_r;
  assign present_position_o = position;
  assign launch_velocity_o = launch_out_r;
  assign move_start_o = move_start_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_request_waits;
    (read_i || write_i) && waitrequest_o;
  endsequence

  sequence s_answer_then_idle;
    !waitrequest_o ##1 waitrequest_o;
  endsequence

  a_bus_one_wait: assert property (s_request_waits |=> s_answer_then_idle)
    else $error("bus answer not given after exactly one wait cycle");

  a_pos_full_write: assert property (
    (pos_load && byteenable_i == 4'hf && !step_i) |=> present_position_o == $past(writedata_i))
    else $error("position write not stored");

  a_move_start_cause: assert property (
    move_start_o |-> $past(pos_load) && $past(mode_i) == MODE_POSITION &&
      $past(ramp_permit_i) && $past(pos_wr_val) != $past(goal_position_i))
    else $error("motion start without a qualifying position write");

  a_move_start_fire: assert property (
    (pos_load && mode_i == MODE_POSITION && ramp_permit_i &&
      pos_wr_val != goal_position_i) |=> move_start_o)
    else $error("qualifying position write did not start motion");

  a_vel_readback: assert property (
    (read_i && waitrequest_o && reg_hit(address_i, IDX_VELOCITY)) ##1 !waitrequest_o
      |-> readdata_o[VEL_W-1:0] == $past(velocity_r))
    else $error("velocity readback mismatch");

  a_step_sign: assert property (
    (step_i && !pos_load && ramp_velocity_i[VEL_W-1]) |=>
      present_position_o == $past(present_position_o) - 32'h0000_0001)
    else $error("negative velocity step did not decrease position");

  a_accel_readback: assert property (
    (read_i && waitrequest_o && reg_hit(address_i, IDX_ACCEL)) |=>
      readdata_o == {{(DATA_W-ACC_W){1'b0}}, $past(ramp_accel_i, 2)})
    else $error("acceleration readback mismatch");

  a_launch_hold: assert property (
    !launch_load |=> $stable(launch_r))
    else $error("launch velocity changed without a write");

  a_launch_gate: assert property (
    mode_i != MODE_POSITION |=> launch_velocity_o == '0)
    else $error("launch velocity applied outside position mode");

  a_upper_zero: assert property (
    (rd_take && !reg_hit(address_i, IDX_POSITION)) |->
      readdata_o[DATA_W-1:VEL_W] == '0)
    else $error("unused upper bits read non-zero");

  a_pos_readback: assert property (
    (read_i && waitrequest_o && reg_hit(address_i, IDX_POSITION)) |=>
      rd_take && readdata_o == $past(position))
    else $error("position readback mismatch");

  a_launch_readback: assert property (
    (read_i && waitrequest_o && reg_hit(address_i, IDX_LAUNCH)) |=>
      rd_take && readdata_o == {{(DATA_W-VST_W){1'b0}}, $past(launch_r)})
    else $error("launch velocity readback mismatch");

endmodule
`default_nettype wire

// *** verilog/ramp_regs_pkg.sv ***
// Shared constants and types for the axis motion-state register block
package ramp_regs_pkg;

  // Bus geometry
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int IDX_W = 6;
  localparam int BE_W = 4;
  localparam int LANE_W = 8;

  // Register indices; the byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_POSITION = 6'h18;
  localparam logic [IDX_W-1:0] IDX_VELOCITY = 6'h19;
  localparam logic [IDX_W-1:0] IDX_ACCEL = 6'h1a;
  localparam logic [IDX_W-1:0] IDX_LAUNCH = 6'h1b;

  // Field widths of the documented registers
  localparam int POS_W = 32;
  localparam int VEL_W_DEF = 24;
  localparam int ACC_W_DEF = 24;
  localparam int VST_W_DEF = 18;

  // Reset values and the value read at unmapped addresses
  localparam logic [POS_W-1:0] POSITION_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] READ_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h0000_0000;

  // Operating modes of the ramp generator
  typedef enum logic [1:0] {
    MODE_POSITION = 2'b00,
    MODE_VEL_POS = 2'b01,
    MODE_VEL_NEG = 2'b10,
    MODE_HOLD = 2'b11
  } motion_mode_t;

endpackage

// *** verilog/axis_position_counter.sv ***
// Signed axis position counter, loaded by software and stepped by the ramp
`timescale 1ns/1ns
`default_nettype none
module axis_position_counter
  import ramp_regs_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [POS_W-1:0] load_val_i,
  input wire logic step_i,
  input wire logic step_down_i,
  output logic [POS_W-1:0] position_o
);

  logic [POS_W-1:0] position_r;
  logic [POS_W-1:0] position_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // A software load in the same cycle as a step wins; the step is dropped
  // because the written value is taken as the new reference point.
  always_comb
  begin
    position_nxt = position_r;
    if (load_i)
    begin
      position_nxt = load_val_i;
    end
    else if (step_i)
    begin
      position_nxt = step_down_i ? position_r - 32'h0000_0001 : position_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      position_r <= POSITION_RST;
    end
    else
    begin
      position_r <= position_nxt;
    end
  end

  assign position_o = position_r;

  ////////////////////////////////////////////////////////////////////////////
  a_step_moves_one: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (step_i && !load_i) |=> (position_r - $past(position_r) ==
      ($past(step_down_i) ? 32'hffff_ffff : 32'h0000_0001)))
    else $error("position did not move by one step in the ramp direction");

endmodule
`default_nettype wire

// *** verification/host_bus_master.sv ***
// Avalon-MM host model that reaches the axis registers
`timescale 1ns/1ns
`default_nettype none
module host_bus_master
(
  input wire logic ref_clk_i,
  input wire logic waitrequest_i,
  input wire logic [31:0] readdata_i,
  output var logic [7:0] address_o,
  output var logic read_o,
  output var logic write_o,
  output var logic [3:0] byteenable_o,
  output var logic [31:0] writedata_o
);
  initial
  begin
    address_o = 8'h00;
    read_o = 1'b0;
    write_o = 1'b0;
    byteenable_o = 4'h0;
    writedata_o = 32'h0000_0000;
  end

  // Request stays put until waitrequest is sampled low; one idle edge after
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [3:0] be,
    input logic [31:0] d, output logic [31:0] q);
    address_o <= a;
    byteenable_o <= be;
    writedata_o <= d;
    write_o <= wr;
    read_o <= !wr;
    do @(posedge ref_clk_i); while (waitrequest_i !== 1'b0);
    q = readdata_i;
    write_o <= 1'b0;
    read_o <= 1'b0;
    // Stale write data would hide a late capture
    writedata_o <= ~d;
    @(posedge ref_clk_i);
  endtask
endmodule
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench for the axis motion-state registers
`timescale 1ns/1ns
`default_nettype none
module tb;
  import ramp_regs_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] address;
  logic read;
  logic write;
  logic [3:0] byteenable;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic waitrequest;
  motion_mode_t mode = MODE_HOLD;
  logic [31:0] goal = 32'h0;
  logic permit = 1'b0;
  logic [23:0] vel = 24'h0;
  logic [23:0] acc = 24'h0;
  logic step = 1'b0;
  logic [31:0] present_position;
  logic [17:0] launch_velocity;
  logic move_start;
  int fail_count = 0;
  int samples_checked = 0;
  int starts = 0;
  int n;
  motion_mode_t tm[4] = '{MODE_POSITION, MODE_POSITION, MODE_POSITION, MODE_HOLD};
  motion_mode_t ml[4] = '{MODE_POSITION, MODE_VEL_POS, MODE_VEL_NEG, MODE_HOLD};
  logic tp[4] = '{1'b1, 1'b1, 1'b0, 1'b1};
  logic [31:0] tv[4] = '{32'h10, 32'h5, 32'h20, 32'h30};
  logic [31:0] te[4] = '{32'h1, 32'h0, 32'h0, 32'h0};
  logic [31:0] q;

  always #50 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i)
    if (move_start === 1'b1)
      starts <= starts + 1;

  ramp_actual_state_regs u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .address_i(address),
    .read_i(read), .write_i(write), .byteenable_i(byteenable), .writedata_i(writedata),
    .readdata_o(readdata), .waitrequest_o(waitrequest), .mode_i(mode),
    .goal_position_i(goal), .ramp_permit_i(permit), .ramp_velocity_i(vel),
    .ramp_accel_i(acc), .step_i(step), .present_position_o(present_position),
    .launch_velocity_o(launch_velocity), .move_start_o(move_start));
  host_bus_master u_host (.ref_clk_i(ref_clk_i), .waitrequest_i(waitrequest),
    .readdata_i(readdata), .address_o(address), .read_o(read), .write_o(write),
    .byteenable_o(byteenable), .writedata_o(writedata));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    u_host.xfer(1'b1, a, be, d, q);
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    u_host.xfer(1'b0, a, 4'hf, 32'h0, d);
    check(what, d, exp);
  endtask
  task automatic close_out;
    if (fail_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Whole sequence needs about 120 cycles
  initial
  begin
    repeat (3000) @(posedge ref_clk_i);
    fail_count++;
    close_out();
  end

  initial
  begin
    repeat (8) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    rdchk("pos_rst", 8'h60, 32'h0);
    rdchk("vel_rst", 8'h64, 32'h0);
    rdchk("acc_rst", 8'h68, 32'h0);
    rdchk("vst_rst", 8'h6c, 32'h0);
    // Position is only altered in hold mode here, so no motion is started
    wr(8'h60, 4'hf, 32'haabbccdd);
    wr(8'h60, 4'h2, 32'h11223344);
    rdchk("pos_lane", 8'h60, 32'haabb33dd);
    for (int i = 0; i < 4; i++)
    begin
      mode <= tm[i];
      permit <= tp[i];
      goal <= 32'h5;
      @(posedge ref_clk_i);
      n = starts;
      wr(8'h60, 4'hf, tv[i]);
      repeat (2) @(posedge ref_clk_i);
      check("move_start", 32'(starts - n), te[i]);
      rdchk("pos_wr", 8'h60, tv[i]);
    end
    vel <= 24'hfffffe;
    acc <= 24'habcdef;
    step <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    step <= 1'b0;
    @(posedge ref_clk_i);
    check("pos_down", present_position, 32'h2d);
    rdchk("vel", 8'h64, 32'h00fffffe);
    wr(8'h64, 4'hf, 32'h12345678);
    rdchk("vel_ro", 8'h64, 32'h00fffffe);
    rdchk("acc", 8'h68, 32'h00abcdef);
    wr(8'h68, 4'hf, 32'hffffffff);
    rdchk("acc_ro", 8'h68, 32'h00abcdef);
    vel <= 24'h000100;
    step <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    step <= 1'b0;
    @(posedge ref_clk_i);
    check("pos_up", present_position, 32'h2f);
    // No halt velocity is modelled here, so any launch value keeps the host rule
    wr(8'h6c, 4'hf, 32'hffffffff);
    rdchk("vst", 8'h6c, 32'h0003ffff);
    for (int m = 0; m < 4; m++)
    begin
      mode <= ml[m];
      repeat (2) @(posedge ref_clk_i);
      check("vst_out", {14'h0, launch_velocity}, (m == 0) ? 32'h3ffff : 32'h0);
    end
    wr(8'h70, 4'hf, 32'hdeadbeef);
    rdchk("unmapped", 8'h70, 32'h0);
    rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    rdchk("pos_rst2", 8'h60, 32'h0);
    rdchk("vst_rst2", 8'h6c, 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
